/* design/vairc_pkg.sv */
// Package for the video input route control block: register map, field
// positions, selector codes and processing-mode codes.
// Assumes one APB slave with 32-bit data and byte addressing.
package vairc_pkg;
    // Printed offsets are not all multiples of four: they are indices
    localparam logic [7:0]  VAIRC_IDX_CONV01     = 8'hC3; // Converters 0 and 1 selectors
    localparam logic [7:0]  VAIRC_IDX_CONV2_MAN  = 8'hC4; // Converter 2 selector, manual enable
    localparam logic [7:0]  VAIRC_IDX_CONV3      = 8'hF3; // Converter 3 selector
    localparam logic [7:0]  VAIRC_IDX_MODE       = 8'hF4; // Processing mode fields
    localparam logic [7:0]  VAIRC_IDX_STATUS     = 8'hF5; // Live connection status
    localparam int          VAIRC_ADDR_W         = 12;    // APB byte address width
    // Field positions
    localparam int          VAIRC_LO_SEL_LSB     = 0;     // Low selector nibble
    localparam int          VAIRC_HI_SEL_LSB     = 4;     // High selector nibble
    localparam int          VAIRC_MAN_EN_BIT     = 7;     // Manual route enable
    localparam int          VAIRC_INSEL_LSB      = 0;     // Input select code
    localparam int          VAIRC_SDFMT_LSB      = 4;     // SD input format
    localparam int          VAIRC_PRIM_LSB       = 8;     // Primary mode
    localparam int          VAIRC_VSTD_LSB       = 12;    // Video standard
    // Reset values
    localparam logic [7:0]  VAIRC_RST_BYTE       = 8'h00;
    localparam logic [15:0] VAIRC_RST_MODE       = 16'h0000;
    // Analog input numbers; zero means no connection
    localparam logic [3:0]  VAIRC_AIN_NONE       = 4'h0;
    // Selector codes
    localparam logic [3:0]  VAIRC_SEL_AIN2       = 4'h1;
    localparam logic [3:0]  VAIRC_SEL_AIN3       = 4'h2;
    localparam logic [3:0]  VAIRC_SEL_AIN5       = 4'h3;
    localparam logic [3:0]  VAIRC_SEL_AIN6       = 4'h4;
    localparam logic [3:0]  VAIRC_SEL_AIN8       = 4'h5;
    localparam logic [3:0]  VAIRC_SEL_AIN10      = 4'h6;
    localparam logic [3:0]  VAIRC_SEL_AIN1       = 4'h9;
    localparam logic [3:0]  VAIRC_SEL_AIN4       = 4'hB;
    localparam logic [3:0]  VAIRC_SEL_AIN7       = 4'hD;
    localparam logic [3:0]  VAIRC_SEL_AIN9       = 4'hE;
    // Video standard codes that steer data to the component processor
    localparam logic [3:0]  VAIRC_VSTD_COMP_YUV  = 4'hA;
    localparam logic [3:0]  VAIRC_VSTD_GRAPHICS  = 4'hC;
endpackage

/* design/vairc_top.sv */
// Video input route control: APB registers driving the analog switch
// selection of four converters plus processing-mode fields.
// Assumes a synchronous APB master on clk; no pins cross domains.
`timescale 1ns/1ps
`default_nettype none
module vairc_top
    import vairc_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [VAIRC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Analog switch selection, one-hot per converter, bit n = input n+1
    output logic      [9:0]              conv0_switch,
    output logic      [9:0]              conv1_switch,
    output logic      [9:0]              conv2_switch,
    output logic      [9:0]              conv3_switch,
    // Processing-mode fields for downstream processors
    output logic      [3:0]              input_select_code,
    output logic      [1:0]              sd_input_format_sel,
    output logic      [3:0]              primary_mode_code,
    output logic      [3:0]              video_standard_code,
    output logic                         component_processor_sel
);
    import vairc_pkg::*;

    // Register state
    logic [7:0]  reg_conv01;        // Converter 0/1 selectors
    logic [7:0]  reg_conv2_man;     // Converter 2 selector and manual enable
    logic [7:0]  reg_conv3;         // Converter 3 selector
    logic [15:0] reg_mode;          // Mode fields
    // Next values of the register state
    logic [7:0]  next_reg_conv01;
    logic [7:0]  next_reg_conv2_man;
    logic [7:0]  next_reg_conv3;
    logic [15:0] next_reg_mode;
    // Read data and error flag prepared in the setup cycle
    logic [31:0] next_prdata;
    logic [39:0] next_switches;
    logic [39:0] switches;      // Registered switch outputs
    logic        next_err;
    logic        err;

    // Byte address of a register index
    // Index times four, zero-extended to the bus width
    function automatic logic [VAIRC_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = {{(VAIRC_ADDR_W-10){1'b0}}, idx, 2'b00};
    endfunction

    // One-hot switch vector for analog input number n (1..10), zero for none
    function automatic logic [9:0] ain_onehot(input logic [3:0] n);
        ain_onehot = (n == VAIRC_AIN_NONE) ? 10'h000 : 10'(10'h001 << (n - 4'h1));
    endfunction

    // Selector decode; each converter honours only its wired subset
    function automatic logic [3:0] decode_sel(input logic [1:0] conv, input logic [3:0] code);
        logic [3:0] ain;
        ain = VAIRC_AIN_NONE;
        case (code)
            VAIRC_SEL_AIN2:  ain = (conv == 2'd0) ? 4'd2 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN3:  ain = (conv == 2'd0 || conv == 2'd2) ? 4'd3 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN5:  ain = (conv <= 2'd1) ? 4'd5 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN6:  ain = 4'd6;
            VAIRC_SEL_AIN8:  ain = (conv != 2'd3) ? 4'd8 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN10: ain = (conv != 2'd3) ? 4'd10 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN1:  ain = (conv == 2'd0 || conv == 2'd3) ? 4'd1 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN4:  ain = (conv <= 2'd1) ? 4'd4 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN7:  ain = (conv != 2'd3) ? 4'd7 : VAIRC_AIN_NONE;
            VAIRC_SEL_AIN9:  ain = (conv != 2'd3) ? 4'd9 : VAIRC_AIN_NONE;
            default:         ain = VAIRC_AIN_NONE;
        endcase
        decode_sel = ain;
    endfunction

    // Register writes, read mux and switch decode
    // Read data is latched in the setup cycle so prdata comes from a flop
    // and stands unchanged through the whole access phase.
    always_comb begin
        // Hold every register unless a write hits it
        next_reg_conv01    = reg_conv01;
        next_reg_conv2_man = reg_conv2_man;
        next_reg_conv3     = reg_conv3;
        next_reg_mode      = reg_mode;
        // Idle bus reads back zero
        next_prdata        = 32'h0000_0000;
        next_err           = 1'b0;
        if (psel && !penable) begin
            // Setup phase: decode and prepare answer for the access cycle
            if (paddr == reg_addr(VAIRC_IDX_CONV01)) begin
                // Converter 0 and 1 selectors
                next_prdata = {24'h000000, reg_conv01};
            end else if (paddr == reg_addr(VAIRC_IDX_CONV2_MAN)) begin
                // Converter 2 selector and manual enable
                next_prdata = {24'h000000, reg_conv2_man};
            end else if (paddr == reg_addr(VAIRC_IDX_CONV3)) begin
                // Converter 3 selector, low nibble reads zero
                next_prdata = {24'h000000, reg_conv3};
            end else if (paddr == reg_addr(VAIRC_IDX_MODE)) begin
                // Processing-mode fields
                next_prdata = {16'h0000, reg_mode};
            end else if (paddr == reg_addr(VAIRC_IDX_STATUS)) begin
                // Live status: every input closed on any converter
                next_prdata = {22'h000000, switches[9:0] | switches[19:10]
                               | switches[29:20] | switches[39:30]};
            end else begin
                next_err = 1'b1;                                             // Unmapped
            end
            // Writes return no data
            if (pwrite) begin
                next_prdata = 32'h0000_0000;
            end
        end
        if (psel && penable && pwrite) begin
            // Access phase: writes land here; unmapped writes are dropped
            if (paddr == reg_addr(VAIRC_IDX_CONV01)) begin
                // Both selector nibbles at once
                next_reg_conv01 = pwdata[7:0];
            end else if (paddr == reg_addr(VAIRC_IDX_CONV2_MAN)) begin
                // Selector plus manual enable in bit 7
                next_reg_conv2_man = pwdata[7:0];
            end else if (paddr == reg_addr(VAIRC_IDX_CONV3)) begin
                // Only the high nibble is implemented
                next_reg_conv3 = pwdata[7:0] & 8'hF0;
            end else if (paddr == reg_addr(VAIRC_IDX_MODE)) begin
                // Mode fields for the downstream processors
                next_reg_mode = pwdata[15:0];
            end
        end
        // Switches close only under manual enable; with it clear every
        // converter is left floating rather than on a stale route.
        next_switches = 40'h00_0000_0000;
        if (reg_conv2_man[VAIRC_MAN_EN_BIT]) begin
            // Converter 0 from the low nibble of the first byte
            next_switches[9:0]   = ain_onehot(decode_sel(2'd0,
                                   reg_conv01[VAIRC_LO_SEL_LSB +: 4]));
            // Converter 1 from the high nibble of the first byte
            next_switches[19:10] = ain_onehot(decode_sel(2'd1,
                                   reg_conv01[VAIRC_HI_SEL_LSB +: 4]));
            // Converter 2 from the low nibble of the enable byte
            next_switches[29:20] = ain_onehot(decode_sel(2'd2,
                                   reg_conv2_man[VAIRC_LO_SEL_LSB +: 4]));
            // Converter 3 from the high nibble of its own byte
            next_switches[39:30] = ain_onehot(decode_sel(2'd3,
                                   reg_conv3[VAIRC_HI_SEL_LSB +: 4]));
        end
    end

    // State registers
    // Switches lag the register write by one edge; the analog front end
    // sees a single clean change per write.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Everything open and cleared
            reg_conv01    <= VAIRC_RST_BYTE;
            reg_conv2_man <= VAIRC_RST_BYTE;
            reg_conv3     <= VAIRC_RST_BYTE;
            reg_mode      <= VAIRC_RST_MODE;
            prdata        <= 32'h0000_0000;
            err           <= 1'b0;
            switches      <= 40'h00_0000_0000;
        end else begin
            reg_conv01    <= next_reg_conv01;
            reg_conv2_man <= next_reg_conv2_man;
            reg_conv3     <= next_reg_conv3;
            reg_mode      <= next_reg_mode;
            // Answer held through the access phase
            prdata   <= (psel && penable) ? prdata : next_prdata;
            err      <= (psel && penable) ? err : next_err;
            switches <= next_switches;
        end
    end

    // APB answers in the first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err;

    // Outputs towards the analog front end and processors
    assign conv0_switch        = switches[9:0];
    assign conv1_switch        = switches[19:10];
    assign conv2_switch        = switches[29:20];
    assign conv3_switch        = switches[39:30];
    assign input_select_code   = reg_mode[VAIRC_INSEL_LSB +: 4];
    assign sd_input_format_sel = reg_mode[VAIRC_SDFMT_LSB +: 2];
    assign primary_mode_code   = reg_mode[VAIRC_PRIM_LSB +: 4];
    assign video_standard_code = reg_mode[VAIRC_VSTD_LSB +: 4];
    // Component standards route data to the component processor
    assign component_processor_sel = (video_standard_code == VAIRC_VSTD_COMP_YUV)
                                   || (video_standard_code == VAIRC_VSTD_GRAPHICS);
endmodule
`default_nettype wire

/* dv/vairc_top_sva.sv */
// Checker for the video input route control block.
// Assumes a bind onto vairc_top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module vairc_top_sva
    import vairc_pkg::*;
(
    // Clock, reset and APB
    input wire logic                    clk, sys_rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [VAIRC_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata, prdata,
    // Switches and mode
    input wire logic [9:0]              conv0_switch, conv1_switch, conv2_switch, conv3_switch,
    input wire logic [3:0]              video_standard_code,
    input wire logic                    component_processor_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic acc;    // Access phase
    logic mapped; // Decoded address
    logic c2_on;  // Write of converter 2 byte with enable and code 5
    assign acc = psel && penable;
    assign mapped = paddr inside {12'h30C, 12'h310, 12'h3CC, 12'h3D0, 12'h3D4};
    assign c2_on = acc && pwrite && paddr == 12'h310 && pwdata[7:0] == 8'h85;
    a_zero_wait: assert property (psel && !penable |=> pready) else $error("ready missing");
    a_unmapped_err: assert property (acc |-> pslverr == !mapped) else $error("bad error flag");
    a_c2_apply: assert property (c2_on |-> ##2 conv2_switch == 10'h080) else $error("c2 route");
    a_man_off: assert property (acc && pwrite && paddr == 12'h310 && !pwdata[7] |-> ##2
        (conv0_switch | conv1_switch | conv2_switch | conv3_switch) == 10'h000) else $error("open");
    a_onehot_sw: assert property ($onehot0(conv0_switch) && $onehot0(conv1_switch) &&
        $onehot0(conv2_switch) && $onehot0(conv3_switch)) else $error("two inputs closed");
    a_conv1_legal: assert property ((conv1_switch & ~10'h3F8) == 10'h000) else $error("c1");
    a_conv2_legal: assert property ((conv2_switch & ~10'h3E4) == 10'h000) else $error("c2");
    a_conv3_legal: assert property ((conv3_switch & ~10'h021) == 10'h000) else $error("c3");
    a_comp_route: assert property (component_processor_sel ==
        (video_standard_code inside {4'hA, 4'hC})) else $error("processor select");
    a_rst_clear: assert property (disable iff (1'b0) sys_rst |=> conv0_switch == 10'h000 &&
        prdata == 32'h0) else $error("reset state");
    c_c2_write: cover property (c2_on);
    c_unmapped: cover property (acc && !mapped);
    c_comp_sel: cover property (component_processor_sel);
endmodule
bind vairc_top vairc_top_sva chk_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .conv0_switch(conv0_switch), .conv1_switch(conv1_switch),
    .conv2_switch(conv2_switch), .conv3_switch(conv3_switch),
    .video_standard_code(video_standard_code), .component_processor_sel(component_processor_sel));
`default_nettype wire

/* dv/vairc_top_test.sv */
// Testbench for the video input route control block.
// Assumes vairc_pkg, vairc_top and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module vairc_top_test;
    import vairc_pkg::*;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, comp, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  sw0, sw1, sw2, sw3;
    logic [3:0]  insel, prim, vstd;
    logic [1:0]  fmt;
    int          n_errors = 0, n_checks = 0;
    // Byte addresses, four times the index
    localparam logic [11:0] A_R01 = {2'b00, VAIRC_IDX_CONV01, 2'b00};
    localparam logic [11:0] A_R2M = {2'b00, VAIRC_IDX_CONV2_MAN, 2'b00};
    localparam logic [11:0] A_R3 = {2'b00, VAIRC_IDX_CONV3, 2'b00};
    localparam logic [11:0] A_MD = {2'b00, VAIRC_IDX_MODE, 2'b00};
    localparam logic [11:0] A_ST = {2'b00, VAIRC_IDX_STATUS, 2'b00};
    // Input number per selector code, one nibble per code
    localparam logic [63:0] MAP0 = 64'h0970_4010_0A86_5320;
    localparam logic [63:0] MAP1 = 64'h0970_4000_0A86_5000;
    localparam logic [63:0] MAP2 = 64'h0970_0000_0A86_0300;
    localparam logic [63:0] MAP3 = 64'h0000_0010_0006_0000;
    // Mode words of the recommended setups
    localparam logic [15:0] MODES [5] = '{16'h2000, 16'h2030, 16'h2009, 16'hA000, 16'hC200};
    vairc_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv0_switch(sw0), .conv1_switch(sw1), .conv2_switch(sw2), .conv3_switch(sw3),
        .input_select_code(insel), .sd_input_format_sel(fmt), .primary_mode_code(prim),
        .video_standard_code(vstd), .component_processor_sel(comp));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            $display("ERROR %0t no ready", $time);
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e); apb(1'b0, a, 0); chk(rd, e); endtask
    // Expected one-hot switch for a code
    function automatic logic [9:0] oh(input logic [63:0] m, input logic [3:0] c);
        logic [3:0] n;
        n = m[c*4+:4];
        return (n == 4'h0) ? 10'h000 : 10'h001 << (n - 4'h1);
    endfunction
    // Every code on every converter, with readback
    task automatic t_routes;
        for (int c = 0; c < 16; c++) begin
            wr(A_R01, {24'h0, c[3:0], c[3:0]});
            wr(A_R2M, {24'h0, 4'h8, c[3:0]});
            wr(A_R3, {24'h0, c[3:0], c[3:0]});
            repeat (2) @(posedge clk);
            chk(sw0, oh(MAP0, c[3:0]));
            chk(sw1, oh(MAP1, c[3:0]));
            chk(sw2, oh(MAP2, c[3:0]));
            chk(sw3, oh(MAP3, c[3:0]));
            rdc(A_R3, {24'h0, c[3:0], 4'h0});
            rdc(A_R2M, {24'h0, 4'h8, c[3:0]});
        end
    endtask
    // Routes of the recommended setups
    task automatic t_setups;
        wr(A_R01, 32'h09); wr(A_R2M, 32'h80); wr(A_R3, 32'h00);
        repeat (2) @(posedge clk);
        chk(sw0, 10'h001);
        wr(A_R01, 32'hED);
        repeat (2) @(posedge clk);
        chk({sw0, sw1}, {10'h040, 10'h100});
        wr(A_R01, 32'h46); wr(A_R2M, 32'h85);
        repeat (2) @(posedge clk);
        chk({sw0, sw1, sw2}, {10'h200, 10'h020, 10'h080});
        wr(A_R01, 32'h6B); wr(A_R3, 32'h40);
        repeat (2) @(posedge clk);
        chk({sw0, sw1, sw2}, {10'h008, 10'h200, 10'h080});
        chk(sw3, 10'h020);
        wr(A_R01, 32'h31); wr(A_R2M, 32'h82); wr(A_R3, 32'h00);
        repeat (2) @(posedge clk);
        chk({sw0, sw1, sw2}, {10'h002, 10'h010, 10'h004});
    endtask
    // Mixed routes, status, then enable cleared
    task automatic t_enable;
        wr(A_R01, 32'h45); wr(A_R2M, 32'h85); wr(A_R3, 32'h90);
        repeat (2) @(posedge clk);
        chk({sw0, sw1, sw2}, {10'h080, 10'h020, 10'h080});
        rdc(A_ST, 32'h0A1);
        wr(A_R2M, 32'h05);
        repeat (2) @(posedge clk);
        chk(sw0 | sw1 | sw2 | sw3, 0);
    endtask
    // Mode fields of each setup
    task automatic t_modes;
        for (int i = 0; i < 5; i++) begin
            wr(A_MD, {16'h0, MODES[i]});
            @(posedge clk);
            chk({vstd, prim, 2'b00, fmt, insel}, MODES[i]);
            chk(comp, MODES[i][15:12] inside {4'hA, 4'hC});
        end
    endtask
    // Unmapped place and upper bits
    task automatic t_unmapped;
        apb(1'b1, 12'h314, 32'hFF); chk(err, 1);
        rdc(12'h314, 0); chk(err, 1);
        rdc(A_R2M, 32'h05);
        wr(A_R01, 32'hABCD_0012); rdc(A_R01, 32'h12);
    endtask
    // Verdict
    task automatic stop_test;
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence: reset values first
    initial begin
        sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (MODES[i]) rdc((i == 4) ? A_ST : (i == 3) ? A_MD : (i == 2) ? A_R3 : (i == 1) ? A_R2M : A_R01, 0);
        t_routes; t_setups; t_enable; t_modes; t_unmapped;
        stop_test;
    end
    // Watchdog
    initial begin
        #100000;
        n_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
